// >>> tccc_pkg.sv
package tccc_pkg;
	// ----------------------------------------
	// Register indices and address width
	// ----------------------------------------
	localparam logic [7:0] IDX_CH0_LOW = 8'hDA;
	localparam logic [7:0] IDX_CH0_HIGH = 8'hDB;
	localparam logic [7:0] IDX_CH1_LOW = 8'hDC;
	localparam logic [7:0] IDX_CH1_HIGH = 8'hDD;
	localparam logic [7:0] IDX_CH2_LOW = 8'hDE;
	localparam logic [7:0] IDX_CH2_HIGH = 8'hDF;
	localparam logic [7:0] IDX_COUNT_LOW = 8'hE2;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'hE3;
	localparam logic [7:0] IDX_TIMER_CTL = 8'hE4;
	localparam logic [7:0] IDX_CH0_CTL = 8'hE5;
	localparam logic [7:0] IDX_CH1_CTL = 8'hE6;
	localparam logic [7:0] IDX_CH2_CTL = 8'hE7;
	localparam logic [7:0] IDX_OVF_MASK = 8'hE8;
	localparam int ADDR_W = 10;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_RSVD_BIT = 7;
	localparam int CTL_MASK_BIT = 6;
	localparam int CTL_ACT_LSB = 3;
	localparam int CTL_FUNC_BIT = 2;
	localparam int CTL_EDGE_LSB = 0;
	localparam logic [7:0] CTL_RESET = 8'h40;
	localparam logic [7:0] VALUE_RESET = 8'h00;
	localparam int TCTL_FLAG_LSB = 5;
	localparam int TCTL_OVF_BIT = 4;
	localparam int TCTL_DIV_LSB = 2;
	localparam int TCTL_MODE_LSB = 0;
	localparam logic [7:0] TCTL_RESET = 8'h00;
	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [2:0] ACT_SET = 3'h0;
	localparam logic [2:0] ACT_CLEAR = 3'h1;
	localparam logic [2:0] ACT_TOGGLE = 3'h2;
	localparam logic [2:0] ACT_SET_UP = 3'h3;
	localparam logic [2:0] ACT_CLEAR_UP = 3'h4;
	localparam logic [2:0] ACT_CLR_BASE = 3'h5;
	localparam logic [2:0] ACT_SET_BASE = 3'h6;
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_MODULO = 2'h2;
	localparam logic [1:0] MODE_UPDOWN = 2'h3;
	localparam logic [6:0] DIV_MASK_1 = 7'h00;
	localparam logic [6:0] DIV_MASK_8 = 7'h07;
	localparam logic [6:0] DIV_MASK_32 = 7'h1F;
	localparam logic [6:0] DIV_MASK_128 = 7'h7F;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage

// >>> tccc_channel.sv
`timescale 1ns/1ps
module tccc_channel
	import tccc_pkg::*;
#(
	parameter bit BASE_PAIR = 1'b1
)(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic count_upd_i,
	input wire logic [15:0] count_i,
	input wire logic step_up_i,
	input wire logic [15:0] value_i,
	input wire logic [15:0] base_value_i,
	input wire logic [7:0] control_i,
	input wire logic pin_i,
	output logic chan_out_o,
	output logic event_o,
	output logic capture_o
);
	logic pin_prev;
	logic compare_mode;
	logic [1:0] edge_sel;
	logic [2:0] action;
	logic own_hit;
	logic base_hit;
	logic zero_hit;
	logic edge_hit;
	logic next_out;

	assign compare_mode = control_i[CTL_FUNC_BIT];
	assign edge_sel = control_i[CTL_EDGE_LSB +: 2];
	assign action = control_i[CTL_ACT_LSB +: 3];
	assign own_hit = count_upd_i && (count_i == value_i);
	assign base_hit = count_upd_i && (count_i == base_value_i);
	assign zero_hit = count_upd_i && (count_i == COUNT_ZERO);

	// ----------------------------------------
	// Capture edge detect
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			pin_prev <= 1'b0;
		else
			pin_prev <= pin_i;
	end

	always_comb
	begin
		case (edge_sel)
			EDGE_RISE: edge_hit = pin_i && !pin_prev;
			EDGE_FALL: edge_hit = !pin_i && pin_prev;
			EDGE_BOTH: edge_hit = pin_i != pin_prev;
			default: edge_hit = 1'b0;
		endcase
	end

	assign capture_o = !compare_mode && edge_hit;
	assign event_o = capture_o || (compare_mode && own_hit);

	// ----------------------------------------
	// Output compare action
	// ----------------------------------------
	always_comb
	begin
		next_out = chan_out_o;
		case (action)
			ACT_SET: if (own_hit) next_out = 1'b1;
			ACT_CLEAR: if (own_hit) next_out = 1'b0;
			ACT_TOGGLE: if (own_hit) next_out = !chan_out_o;
			ACT_SET_UP:
			begin
				if (own_hit && step_up_i)
					next_out = 1'b1;
				else if (zero_hit || (own_hit && !step_up_i))
					next_out = 1'b0;
			end
			ACT_CLEAR_UP:
			begin
				if (own_hit && step_up_i)
					next_out = 1'b0;
				else if (zero_hit || (own_hit && !step_up_i))
					next_out = 1'b1;
			end
			ACT_CLR_BASE:
			begin
				if (BASE_PAIR && own_hit)
					next_out = 1'b1;
				else if (BASE_PAIR && base_hit)
					next_out = 1'b0;
			end
			ACT_SET_BASE:
			begin
				if (BASE_PAIR && own_hit)
					next_out = 1'b0;
				else if (BASE_PAIR && base_hit)
					next_out = 1'b1;
			end
			default: next_out = chan_out_o;
		endcase
		if (!compare_mode)
			next_out = chan_out_o;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			chan_out_o <= 1'b0;
		else
			chan_out_o <= next_out;
	end
endmodule

// >>> tccc_top.sv
`timescale 1ns/1ps
module tccc_top
	import tccc_pkg::*;
#(
	parameter int CHANNELS = 3
)(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [CHANNELS-1:0] chan_pin_i,
	output logic [CHANNELS-1:0] chan_out_o,
	output logic irq_o
);
	logic [7:0] chan_ctl [CHANNELS];
	logic [15:0] chan_value [CHANNELS];
	logic [CHANNELS-1:0] chan_event;
	logic [CHANNELS-1:0] chan_capture;
	logic [CHANNELS-1:0] chan_flag;
	logic ovf_flag;
	logic ovf_mask;
	logic [1:0] div_sel;
	logic [1:0] mode_sel;
	logic [6:0] div_cnt;
	logic [6:0] div_mask;
	logic tick;
	logic [15:0] count;
	logic [15:0] next_count;
	logic step_up;
	logic next_step_up;
	logic count_upd;
	logic wrap_event;
	logic [7:0] count_high_buf;
	logic setup;
	logic wr_go;
	logic [7:0] idx;
	logic idx_ok;
	logic [7:0] rd_byte;
	logic rd_hit;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign setup = psel_i && !penable_i;
	assign wr_go = psel_i && penable_i && pready_o && pwrite_i;
	assign idx_ok = (paddr_i[1:0] == 2'h0);
	assign idx = paddr_i[9:2];

	// ----------------------------------------
	// Read data mux
	// ----------------------------------------
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit = idx_ok;
		if (idx == IDX_CH0_LOW)
			rd_byte = chan_value[0][7:0];
		else if (idx == IDX_CH0_HIGH)
			rd_byte = chan_value[0][15:8];
		else if (idx == IDX_CH1_LOW)
			rd_byte = chan_value[1][7:0];
		else if (idx == IDX_CH1_HIGH)
			rd_byte = chan_value[1][15:8];
		else if (idx == IDX_CH2_LOW)
			rd_byte = chan_value[2][7:0];
		else if (idx == IDX_CH2_HIGH)
			rd_byte = chan_value[2][15:8];
		else if (idx == IDX_COUNT_LOW)
			rd_byte = count[7:0];
		else if (idx == IDX_COUNT_HIGH)
			rd_byte = count_high_buf;
		else if (idx == IDX_TIMER_CTL)
			rd_byte = {chan_flag[2], chan_flag[1], chan_flag[0], ovf_flag, div_sel, mode_sel};
		else if (idx == IDX_CH0_CTL)
			rd_byte = chan_ctl[0];
		else if (idx == IDX_CH1_CTL)
			rd_byte = chan_ctl[1];
		else if (idx == IDX_CH2_CTL)
			rd_byte = chan_ctl[2];
		else if (idx == IDX_OVF_MASK)
			rd_byte = {7'h00, ovf_mask};
		else
			rd_hit = 1'b0;
		if (!idx_ok)
			rd_hit = 1'b0;
	end

	// ----------------------------------------
	// Bus response
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			pready_o <= 1'b0;
		else
			pready_o <= psel_i && penable_i && !pready_o;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end
		else if (setup)
		begin
			prdata_o <= pwrite_i ? 32'h0000_0000 : {24'h000000, rd_byte};
			pslverr_o <= !rd_hit;
		end
	end

	// ----------------------------------------
	// Counter high byte buffer
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			count_high_buf <= 8'h00;
		else if (setup && !pwrite_i && idx_ok && idx == IDX_COUNT_LOW)
			count_high_buf <= count[15:8];
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			div_sel <= TCTL_RESET[TCTL_DIV_LSB +: 2];
			mode_sel <= TCTL_RESET[TCTL_MODE_LSB +: 2];
			ovf_mask <= 1'b0;
		end
		else if (wr_go && idx_ok && idx == IDX_TIMER_CTL)
		begin
			div_sel <= pwdata_i[TCTL_DIV_LSB +: 2];
			mode_sel <= pwdata_i[TCTL_MODE_LSB +: 2];
		end
		else if (wr_go && idx_ok && idx == IDX_OVF_MASK)
			ovf_mask <= pwdata_i[0];
	end

	// ----------------------------------------
	// Per channel registers and logic
	// ----------------------------------------
	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_chan
		localparam logic [7:0] IDX_LOW = IDX_CH0_LOW + 8'(2 * c);
		localparam logic [7:0] IDX_CTL = IDX_CH0_CTL + 8'(c);

		always_ff @(posedge core_clk_i)
		begin
			if (reset_i)
				chan_ctl[c] <= CTL_RESET;
			else if (wr_go && idx_ok && idx == IDX_CTL)
				chan_ctl[c] <= pwdata_i[7:0];
		end

		always_ff @(posedge core_clk_i)
		begin
			if (reset_i)
				chan_value[c] <= {VALUE_RESET, VALUE_RESET};
			else if (chan_capture[c])
				chan_value[c] <= count;
			else if (wr_go && idx_ok && idx == IDX_LOW)
				chan_value[c][7:0] <= pwdata_i[7:0];
			else if (wr_go && idx_ok && idx == IDX_LOW + 8'h01)
				chan_value[c][15:8] <= pwdata_i[7:0];
		end

		always_ff @(posedge core_clk_i)
		begin
			if (reset_i)
				chan_flag[c] <= 1'b0;
			else if (chan_event[c])
				chan_flag[c] <= 1'b1;
			else if (wr_go && idx_ok && idx == IDX_TIMER_CTL && !pwdata_i[TCTL_FLAG_LSB + c])
				chan_flag[c] <= 1'b0;
		end

		// ----------------------------------------
		// Channel compare and capture logic
		// ----------------------------------------
		tccc_channel #(
			.BASE_PAIR(c != 0)
		) u_chan (
			.core_clk_i(core_clk_i),
			.reset_i(reset_i),
			.count_upd_i(count_upd),
			.count_i(count),
			.step_up_i(step_up),
			.value_i(chan_value[c]),
			.base_value_i(chan_value[0]),
			.control_i(chan_ctl[c]),
			.pin_i(chan_pin_i[c]),
			.chan_out_o(chan_out_o[c]),
			.event_o(chan_event[c]),
			.capture_o(chan_capture[c])
		);
	end

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------
	always_comb
	begin
		case (div_sel)
			2'h1: div_mask = DIV_MASK_8;
			2'h2: div_mask = DIV_MASK_32;
			2'h3: div_mask = DIV_MASK_128;
			default: div_mask = DIV_MASK_1;
		endcase
	end

	assign tick = (mode_sel != MODE_STOP) && ((div_cnt & div_mask) == div_mask);

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i || mode_sel == MODE_STOP)
			div_cnt <= 7'h00;
		else
			div_cnt <= div_cnt + 7'h01;
	end

	// ----------------------------------------
	// Counter next state
	// ----------------------------------------
	always_comb
	begin
		next_count = count;
		next_step_up = step_up;
		wrap_event = 1'b0;
		case (mode_sel)
			MODE_FREE:
			begin
				next_count = count + 16'h0001;
				next_step_up = 1'b1;
				wrap_event = count == COUNT_TOP;
			end
			MODE_MODULO:
			begin
				next_step_up = 1'b1;
				wrap_event = count >= chan_value[0];
				next_count = wrap_event ? COUNT_ZERO : count + 16'h0001;
			end
			MODE_UPDOWN:
			begin
				if (step_up ? (count >= chan_value[0]) : (count == COUNT_ZERO))
					next_step_up = !step_up;
				if (chan_value[0] == COUNT_ZERO)
					next_count = COUNT_ZERO;
				else
					next_count = next_step_up ? count + 16'h0001 : count - 16'h0001;
			end
			default: next_count = count;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i || (wr_go && idx_ok && idx == IDX_COUNT_LOW))
		begin
			count <= COUNT_ZERO;
			step_up <= 1'b1;
			count_upd <= 1'b0;
		end
		else
		begin
			count_upd <= tick;
			if (tick)
			begin
				count <= next_count;
				step_up <= next_step_up;
			end
		end
	end

	// ----------------------------------------
	// Overflow interrupt flag
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			ovf_flag <= 1'b0;
		else if (tick && wrap_event)
			ovf_flag <= 1'b1;
		else if (wr_go && idx_ok && idx == IDX_TIMER_CTL && !pwdata_i[TCTL_OVF_BIT])
			ovf_flag <= 1'b0;
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			irq_o <= 1'b0;
		else
			irq_o <= (ovf_flag && ovf_mask) || (chan_flag[0] && chan_ctl[0][CTL_MASK_BIT])
				|| (chan_flag[1] && chan_ctl[1][CTL_MASK_BIT])
				|| (chan_flag[2] && chan_ctl[2][CTL_MASK_BIT]);
	end
endmodule

// >>> tccc_checker.sv
`timescale 1ns/1ps
module tccc_checker
	import tccc_pkg::*;
#(
	parameter int CHANNELS = 3
)(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [CHANNELS-1:0] chan_pin_i,
	input wire logic [CHANNELS-1:0] chan_out_o,
	input wire logic irq_o
);
	// ----
	// Control shadow
	// ----
	logic [7:0] sh [3];
	logic [2:0] masks;
	assign masks = {sh[2][6], sh[1][6], sh[0][6]};
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			sh <= '{CTL_RESET, CTL_RESET, CTL_RESET};
		else if (psel_i && penable_i && pwrite_i && pready_o
			&& paddr_i[9:2] >= IDX_CH0_CTL && paddr_i[9:2] <= IDX_CH2_CTL)
			sh[paddr_i[3:2] - 2'd1] <= pwdata_i[7:0];
	end
	// ----
	// Properties
	// ----
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	property p_ready;
		psel_i && !penable_i |-> ##2 pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("late answer");
	property p_pulse;
		pready_o |=> !pready_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_rdata;
		pready_o |-> prdata_o[31:8] == 24'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("upper data set");
	property p_err;
		pready_o && paddr_i[9:2] == 8'h00 |-> pslverr_o;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_irq_mask;
		irq_o |-> $past(masks) != 3'h0;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
	property p_cap_hold;
		(sh[2][2] == 1'b0) [*3] |=> $stable(chan_out_o[2]);
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("capture moved");
	property p_cap_irq;
		sh[2][6] && sh[2][2:0] == 3'b001 && $rose(chan_pin_i[2]) |-> ##[1:3] irq_o;
	endproperty
	a_cap_irq: assert property (p_cap_irq) else $error("no irq");
	property p_set_hold;
		(sh[1][5:2] == 4'b0001) [*3] |=> !$fell(chan_out_o[1]);
	endproperty
	a_set_hold: assert property (p_set_hold) else $error("set fell");
	property p_clr_hold;
		(sh[1][5:2] == 4'b0011) [*3] |=> !$rose(chan_out_o[1]);
	endproperty
	a_clr_hold: assert property (p_clr_hold) else $error("clear rose");
	c_write: cover property (psel_i && penable_i && pwrite_i && pready_o);
	c_irq: cover property (irq_o);
	c_out: cover property ($rose(chan_out_o[2]));
endmodule
bind tccc_top tccc_checker #(.CHANNELS(CHANNELS)) u_checker (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .chan_pin_i(chan_pin_i),
	.chan_out_o(chan_out_o), .irq_o(irq_o));

// >>> tccc_pin_model.sv
`timescale 1ns/1ps
module tccc_pin_model (
	input wire logic core_clk_i,
	output logic [2:0] pin_o
);
	initial pin_o = 3'h0;
	task set_pin(input int ch, input logic v);
		@(posedge core_clk_i);
		pin_o[ch] <= v;
	endtask
endmodule

// >>> timer_three_channel_capcmp_bench.sv
`timescale 1ns/1ps
module timer_three_channel_capcmp_bench
	import tccc_pkg::*;
;
	logic core_clk_i = 0;
	logic reset_i = 1;
	logic psel_i = 0;
	logic penable_i = 0;
	logic pwrite_i = 0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [31:0] prdata_o, rdata;
	logic pready_o, pslverr_o, irq_o, err, a;
	logic [2:0] chan_pin_i, chan_out_o;
	int n_mismatch = 0;
	int tests_run = 0;
	always #20 core_clk_i = ~core_clk_i;
	tccc_top dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .chan_pin_i(chan_pin_i),
		.chan_out_o(chan_out_o), .irq_o(irq_o));
	tccc_pin_model pins (.core_clk_i(core_clk_i), .pin_o(chan_pin_i));
	// ----
	// Tasks
	// ----
	task print_verdict;
		$display("tests run %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do
			@(posedge core_clk_i);
		while (pready_o !== 1'b1);
		rdata = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task rd(input logic [7:0] idx, input logic [31:0] exp, input string name);
		apb(1'b0, idx, 32'h0);
		chk(name, rdata, exp);
	endtask
	task meas(input logic [1:0] mode, input logic [7:0] idx, input logic [7:0] ctl,
		input int ch, input logic [31:0] exp);
		logic [31:0] ones;
		apb(1'b1, IDX_TIMER_CTL, {30'h0, mode});
		apb(1'b1, idx, {24'h0, ctl});
		repeat (40) @(posedge core_clk_i);
		ones = 0;
		repeat (56)
		begin
			@(posedge core_clk_i);
			ones = ones + {31'h0, chan_out_o[ch]};
		end
		chk("high cycles", ones, exp);
	endtask
	// ----
	// Tests
	// ----
	initial
	begin
		#(40 * 20000);
		n_mismatch++;
		print_verdict;
	end
	initial
	begin
		repeat (10) @(posedge core_clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 3; i++) rd(8'(IDX_CH0_CTL + i), 32'h40, "control");
		for (int i = 0; i < 6; i++) rd(8'(IDX_CH0_LOW + i), 32'h0, "value");
		rd(8'h00, 32'h0, "unmapped");
		chk("unmapped error", {31'h0, err}, 32'h1);
		$display("test reset done");
		apb(1'b1, IDX_CH2_HIGH, 32'h5A);
		rd(IDX_CH2_HIGH, 32'h5A, "value high");
		apb(1'b1, IDX_CH2_HIGH, 32'h0);
		apb(1'b1, IDX_CH2_LOW, 32'h1);
		apb(1'b1, IDX_CH1_LOW, 32'h2);
		apb(1'b1, IDX_CH0_LOW, 32'h7);
		rd(IDX_CH0_LOW, 32'h7, "value low");
		// Reserved bit 7 stays zero; unused codes are never written
		meas(MODE_MODULO, IDX_CH1_CTL, 8'h44, 1, 56);
		meas(MODE_MODULO, IDX_CH1_CTL, 8'h4C, 1, 0);
		meas(MODE_MODULO, IDX_CH1_CTL, 8'h5C, 1, 42);
		meas(MODE_MODULO, IDX_CH0_CTL, 8'h5C, 0, 7);
		apb(1'b1, IDX_CH0_CTL, 32'h40);
		meas(MODE_UPDOWN, IDX_CH1_CTL, 8'h5C, 1, 40);
		meas(MODE_UPDOWN, IDX_CH1_CTL, 8'h64, 1, 16);
		meas(MODE_MODULO, IDX_CH1_CTL, 8'h6C, 1, 35);
		meas(MODE_MODULO, IDX_CH1_CTL, 8'h74, 1, 21);
		meas(MODE_MODULO, IDX_CH2_CTL, 8'h6C, 2, 42);
		meas(MODE_MODULO, IDX_CH2_CTL, 8'h74, 2, 14);
		apb(1'b1, IDX_CH1_CTL, 32'h54);
		repeat (40) @(posedge core_clk_i);
		a = chan_out_o[1];
		repeat (8) @(posedge core_clk_i);
		chk("toggle", {31'h0, chan_out_o[1]}, {31'h0, ~a});
		rd(IDX_TIMER_CTL, 32'hD2, "flags");
		chk("irq", {31'h0, irq_o}, 32'h1);
		apb(1'b1, IDX_CH1_CTL, 32'h14);
		apb(1'b1, IDX_CH2_CTL, 32'h40);
		apb(1'b1, IDX_TIMER_CTL, 32'h0);
		repeat (3) @(posedge core_clk_i);
		chk("irq off", {31'h0, irq_o}, 32'h0);
		$display("test compare done");
		apb(1'b1, IDX_TIMER_CTL, 32'h0);
		apb(1'b1, IDX_COUNT_LOW, 32'h0);
		for (int e = 0; e < 4; e++)
		begin
			apb(1'b1, IDX_CH2_CTL, 32'h40 | e);
			pins.set_pin(2, 1'b1);
			repeat (4) @(posedge core_clk_i);
			rd(IDX_TIMER_CTL, {24'h0, e[0], 7'h0}, "rise flag");
			apb(1'b1, IDX_TIMER_CTL, 32'hE0);
			rd(IDX_TIMER_CTL, {24'h0, e[0], 7'h0}, "flag kept");
			apb(1'b1, IDX_TIMER_CTL, 32'h0);
			pins.set_pin(2, 1'b0);
			repeat (4) @(posedge core_clk_i);
			rd(IDX_TIMER_CTL, {24'h0, e[1], 7'h0}, "fall flag");
			apb(1'b1, IDX_TIMER_CTL, 32'h0);
		end
		rd(IDX_CH2_LOW, 32'h0, "captured");
		$display("test capture done");
		print_verdict;
	end
endmodule
